//--- verilog/pfs_status.sv
// Primary-side fault status word, bits 8..0, read-only to software.
// Assumes detector inputs and mode are synchronous to CLK.
`timescale 1ns/1ps
module pfs_status #(
    parameter int TRIM_W = 64
) (
    // Clock and reset
    input  wire logic                        CLK,
    input  wire logic                        RESET_N,
    input  wire logic                        CE,
    // Operating state
    input  wire pfs_pkg::pfs_mode_t          MODE,
    // Detector levels
    input  wire logic                        RAIL_FAULT,
    input  wire logic                        LINK_FAULT,
    input  wire logic                        SELFTEST_DONE,
    input  wire logic                        SELFTEST_PASS,
    input  wire logic                        CLOCK_MISMATCH,
    // Configuration registers
    input  wire logic [pfs_pkg::CFG_W-1:0]   CFG_A,
    input  wire logic [pfs_pkg::CFG_W-1:0]   CFG_B,
    input  wire logic [pfs_pkg::CFG_W-1:0]   CFG_C,
    input  wire logic                        TEST_REG_WRITE,
    input  wire logic                        RESERVED_WRITE,
    // Trim data
    input  wire logic [TRIM_W-1:0]           TRIM_DATA,
    // Output enable
    input  wire logic                        ENABLE_CMD,
    input  wire logic                        DISABLE_CMD,
    // Pin routing
    input  wire logic [pfs_pkg::N_SRC-1:0]   ALARM_ROUTE,
    input  wire logic [pfs_pkg::N_SRC-1:0]   WARN_ROUTE,
    // Status word
    output logic      [pfs_pkg::WORD_W-1:0]  STATUS
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [pfs_pkg::WORD_W-1:0]           word;
        logic [pfs_pkg::N_CFG*pfs_pkg::CFG_W-1:0] cfg_prev;
        logic                                 cfg_valid;
        logic [pfs_pkg::CRC_W-1:0]            trim_ref;
        logic                                 trim_armed;
        logic                                 selftest_fail;
        logic                                 cfg_fault;
        logic                                 trim_fault;
        logic                                 enabled;
    } pfs_state_t;

    pfs_state_t                  r;
    pfs_state_t                  next_r;
    logic [pfs_pkg::CRC_W-1:0]   trim_crc;
    logic [pfs_pkg::N_SRC-1:0]   src;
    logic [pfs_pkg::N_SRC-1:0]   alarm_hit;
    logic [pfs_pkg::N_SRC-1:0]   warn_hit;
    logic [pfs_pkg::N_CFG*pfs_pkg::CFG_W-1:0] cfg_now;
    logic                        supervise;
    logic                        alarm_any;
    logic                        warn_any;

    pfs_crc #(.DATA_W(TRIM_W)) u_crc (
        .data (TRIM_DATA),
        .crc  (trim_crc)
    );

    assign cfg_now   = {CFG_A, CFG_B, CFG_C};
    assign supervise = (MODE == pfs_pkg::PFS_ST_CONFIG2) ||
                       (MODE == pfs_pkg::PFS_ST_ACTIVE);

    // ==========================================================
    // Routable fault sources, one per word bit 8..3; positions 2..0 are tied to zero
    assign src = {RAIL_FAULT, LINK_FAULT, r.selftest_fail, CLOCK_MISMATCH,
                  r.cfg_fault, r.trim_fault, 1'b0, 1'b0, 1'b0};

    generate
        for (genvar g = 0; g < pfs_pkg::N_SRC; g++) begin : g_route
            assign alarm_hit[g] = src[g] & ALARM_ROUTE[g];
            assign warn_hit[g]  = src[g] & WARN_ROUTE[g];
        end
    endgenerate

    assign alarm_any = |alarm_hit;
    assign warn_any  = |warn_hit;

    // ==========================================================
    // Next state
    always_comb begin
        next_r = r;
        if (SELFTEST_DONE && !SELFTEST_PASS) begin
            next_r.selftest_fail = 1'b1;
        end
        // Config change watch, only counts in active mode
        next_r.cfg_prev  = cfg_now;
        next_r.cfg_valid = 1'b1;
        if (MODE == pfs_pkg::PFS_ST_ACTIVE && r.cfg_valid &&
            cfg_now != r.cfg_prev) begin
            next_r.cfg_fault = 1'b1;
        end
        if (MODE == pfs_pkg::PFS_ST_CONFIG2 &&
            (TEST_REG_WRITE || RESERVED_WRITE)) begin
            next_r.cfg_fault = 1'b1;
        end
        // Trim reference captured on entry to supervision
        if (supervise) begin
            next_r.trim_armed = 1'b1;
            if (!r.trim_armed) begin
                next_r.trim_ref = trim_crc;
            end else if (trim_crc != r.trim_ref) begin
                next_r.trim_fault = 1'b1;
            end
        end else begin
            next_r.trim_armed = 1'b0;
        end
        if (ENABLE_CMD) begin
            next_r.enabled = 1'b1;
        end else if (DISABLE_CMD) begin
            next_r.enabled = 1'b0;
        end
        next_r.word = pfs_pkg::STATUS_RESET;
        next_r.word[pfs_pkg::BIT_RAIL_SUPPLY] = RAIL_FAULT;
        next_r.word[pfs_pkg::BIT_LINK]        = LINK_FAULT;
        next_r.word[pfs_pkg::BIT_SELFTEST]    = next_r.selftest_fail;
        next_r.word[pfs_pkg::BIT_CLOCK]       = CLOCK_MISMATCH;
        next_r.word[pfs_pkg::BIT_CONFIG]      = next_r.cfg_fault;
        next_r.word[pfs_pkg::BIT_TRIM]        = next_r.trim_fault;
        next_r.word[pfs_pkg::BIT_ENABLE]      = next_r.enabled;
        next_r.word[pfs_pkg::BIT_ALARM_OR]    = alarm_any;
        next_r.word[pfs_pkg::BIT_WARN_OR]     = warn_any;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
        end else if (CE) begin
            r <= next_r;
        end
    end

    assign STATUS = r.word;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    rail_bit_a: assert property (
        CE |=> STATUS[pfs_pkg::BIT_RAIL_SUPPLY] == $past(RAIL_FAULT))
        else $error("rail bit wrong");
    link_bit_a: assert property (
        CE |=> STATUS[pfs_pkg::BIT_LINK] == $past(LINK_FAULT))
        else $error("link bit wrong");
    selftest_set_a: assert property (
        CE && SELFTEST_DONE && !SELFTEST_PASS
        |=> STATUS[pfs_pkg::BIT_SELFTEST])
        else $error("selftest fail missed");
    selftest_hold_a: assert property (
        STATUS[pfs_pkg::BIT_SELFTEST] |=> STATUS[pfs_pkg::BIT_SELFTEST])
        else $error("selftest fault dropped");
    clock_bit_a: assert property (
        CE |=> STATUS[pfs_pkg::BIT_CLOCK] == $past(CLOCK_MISMATCH))
        else $error("clock bit wrong");
    cfg_change_a: assert property (
        CE && MODE == pfs_pkg::PFS_ST_ACTIVE &&
        r.cfg_valid && cfg_now != r.cfg_prev
        |=> STATUS[pfs_pkg::BIT_CONFIG])
        else $error("config change missed");
    cfg_quiet_a: assert property (
        CE && MODE != pfs_pkg::PFS_ST_ACTIVE &&
        MODE != pfs_pkg::PFS_ST_CONFIG2 && !r.cfg_fault
        |=> !r.cfg_fault)
        else $error("config fault outside watched states");
    cfg_write_a: assert property (
        CE && MODE == pfs_pkg::PFS_ST_CONFIG2 &&
        (TEST_REG_WRITE || RESERVED_WRITE)
        |=> STATUS[pfs_pkg::BIT_CONFIG])
        else $error("forbidden write missed");
    trim_change_a: assert property (
        CE && supervise && r.trim_armed && trim_crc != r.trim_ref
        |=> STATUS[pfs_pkg::BIT_TRIM])
        else $error("trim change missed");
    trim_idle_a: assert property (
        CE && !supervise |=> !r.trim_armed)
        else $error("trim watched outside states");
    trim_quiet_a: assert property (
        CE && !supervise && !r.trim_fault |=> !r.trim_fault)
        else $error("trim fault outside watched states");
    enable_bit_a: assert property (
        CE && ENABLE_CMD |=> STATUS[pfs_pkg::BIT_ENABLE])
        else $error("enable not shown");
    disable_bit_a: assert property (
        CE && DISABLE_CMD && !ENABLE_CMD
        |=> !STATUS[pfs_pkg::BIT_ENABLE])
        else $error("disable not shown");
    alarm_or_a: assert property (
        CE |=> STATUS[pfs_pkg::BIT_ALARM_OR] == $past(alarm_any))
        else $error("alarm or wrong");
    warn_or_a: assert property (
        CE |=> STATUS[pfs_pkg::BIT_WARN_OR] == $past(warn_any))
        else $error("warning or wrong");
    upper_zero_a: assert property (
        STATUS[pfs_pkg::WORD_W-1:pfs_pkg::BIT_RAIL_SUPPLY+1] == '0)
        else $error("upper bits not zero");
    ce_freeze_a: assert property (
        !CE |=> $stable(STATUS))
        else $error("status moved while frozen");

    // ==========================================================
    // Cover points
    cov_cfg_c:  cover property (STATUS[4]);
    cov_trim_c: cover property (STATUS[3]);
    cov_en_c:   cover property (!STATUS[2] ##1 STATUS[2]);
    cov_self_c: cover property (STATUS[6]);
endmodule : pfs_status

//--- verilog/pfs_pkg.sv
// Constants for the primary-side fault status word (bits 8..0 of 16).
// Assumes one 50 MHz clock domain and an asynchronous active-low reset.
package pfs_pkg;
    // ==========================================================
    // Word layout
    localparam int WORD_W            = 16;
    localparam int BIT_RAIL_SUPPLY   = 8;
    localparam int BIT_LINK          = 7;
    localparam int BIT_SELFTEST      = 6;
    localparam int BIT_CLOCK         = 5;
    localparam int BIT_CONFIG        = 4;
    localparam int BIT_TRIM          = 3;
    localparam int BIT_ENABLE        = 2;
    localparam int BIT_ALARM_OR      = 1;
    localparam int BIT_WARN_OR       = 0;
    localparam int N_SRC             = 9;
    localparam int CFG_W             = 16;
    localparam int N_CFG             = 3;
    localparam int CRC_W             = 16;
    localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
    localparam logic [CRC_W-1:0]  CRC_POLY     = 16'h1021;
    localparam logic [CRC_W-1:0]  CRC_SEED     = 16'hffff;

    // ==========================================================
    // Operating states
    typedef enum logic [1:0] {
        PFS_ST_CONFIG1,
        PFS_ST_CONFIG2,
        PFS_ST_ACTIVE,
        PFS_ST_OTHER
    } pfs_mode_t;
endpackage : pfs_pkg

//--- verilog/pfs_crc.sv
// Combinational CRC-16 over a data word; used for trim supervision.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module pfs_crc #(
    parameter int DATA_W = 64
) (
    // Data in
    input  wire logic [DATA_W-1:0]          data,
    // Checksum out
    output logic      [pfs_pkg::CRC_W-1:0]  crc
);
    always_comb begin
        logic [pfs_pkg::CRC_W-1:0] c;
        c = pfs_pkg::CRC_SEED;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (c[pfs_pkg::CRC_W-1] ^ data[i]) begin
                c = {c[pfs_pkg::CRC_W-2:0], 1'b0} ^ pfs_pkg::CRC_POLY;
            end else begin
                c = {c[pfs_pkg::CRC_W-2:0], 1'b0};
            end
        end
        crc = c;
    end
endmodule : pfs_crc

//--- test/pfs_host.sv
// Host model: captures the status word when a read is requested.
// Assumes the read request is synchronous to the status clock.
`timescale 1ns/1ps
module pfs_host (
    // Clock
    input  wire logic                        clk,
    // Read port
    input  wire logic                        rd,
    input  wire logic [pfs_pkg::WORD_W-1:0]  status,
    output logic      [pfs_pkg::WORD_W-1:0]  word
);
    // ==========================================================
    // Capture
    always_ff @(posedge clk) begin
        if (rd) begin
            word <= status;
        end
    end
endmodule : pfs_host

//--- test/test_primary_side_fault_status.sv
// Bench for the primary fault status word, read through the host model.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module test_primary_side_fault_status;
    logic               CLK = 1'b0;
    logic               RESET_N = 1'b0;
    logic               CE = 1'b1;
    pfs_pkg::pfs_mode_t MODE = pfs_pkg::PFS_ST_CONFIG1;
    logic               RAIL_FAULT = 1'b0, LINK_FAULT = 1'b0;
    logic               SELFTEST_DONE = 1'b0, SELFTEST_PASS = 1'b1;
    logic               CLOCK_MISMATCH = 1'b0;
    logic [15:0]        CFG_A = 16'h0000, CFG_B = 16'h0000;
    logic [15:0]        CFG_C = 16'h0000;
    logic               TEST_REG_WRITE = 1'b0, RESERVED_WRITE = 1'b0;
    logic [63:0]        TRIM_DATA = 64'h0;
    logic               ENABLE_CMD = 1'b0, DISABLE_CMD = 1'b0;
    logic [8:0]         ALARM_ROUTE = 9'h000, WARN_ROUTE = 9'h000;
    logic [15:0]        STATUS, word;
    logic               rd = 1'b0;
    int                 n_mismatch = 0, n_compared = 0, cyc = 0;

    pfs_status #(.TRIM_W(64)) u_dut (.CLK(CLK), .RESET_N(RESET_N),
        .CE(CE), .MODE(MODE), .RAIL_FAULT(RAIL_FAULT),
        .LINK_FAULT(LINK_FAULT), .SELFTEST_DONE(SELFTEST_DONE),
        .SELFTEST_PASS(SELFTEST_PASS), .CLOCK_MISMATCH(CLOCK_MISMATCH),
        .CFG_A(CFG_A), .CFG_B(CFG_B), .CFG_C(CFG_C),
        .TEST_REG_WRITE(TEST_REG_WRITE), .RESERVED_WRITE(RESERVED_WRITE),
        .TRIM_DATA(TRIM_DATA), .ENABLE_CMD(ENABLE_CMD),
        .DISABLE_CMD(DISABLE_CMD), .ALARM_ROUTE(ALARM_ROUTE),
        .WARN_ROUTE(WARN_ROUTE), .STATUS(STATUS));
    pfs_host u_host (.clk(CLK), .rd(rd), .status(STATUS), .word(word));

    // ==========================================================
    // Clock and hang guard
    initial begin
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ==========================================================
    // Tasks
    task tick(input int n);
        repeat (n) @(posedge CLK);
    endtask : tick
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task read_chk(input logic [15:0] exp);
        tick(2);
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(1);
        check(word, exp);
    endtask : read_chk
    task rst;
        RESET_N <= 1'b0;
        MODE    <= pfs_pkg::PFS_ST_CONFIG1;
        tick(2);
        RESET_N <= 1'b1;
        tick(1);
    endtask : rst
    task print_verdict;
        if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Sequence
    initial begin
        tick(12);
        RESET_N <= 1'b1;
        tick(1);
        read_chk(16'h0000);
        RAIL_FAULT     <= 1'b1;
        LINK_FAULT     <= 1'b1;
        CLOCK_MISMATCH <= 1'b1;
        ALARM_ROUTE    <= 9'h100;
        WARN_ROUTE     <= 9'h080;
        read_chk(16'h01a3);
        CLOCK_MISMATCH <= 1'b0;
        ALARM_ROUTE    <= 9'h020;
        WARN_ROUTE     <= 9'h000;
        read_chk(16'h0180);
        RAIL_FAULT <= 1'b0;
        LINK_FAULT <= 1'b0;
        read_chk(16'h0000);
        ENABLE_CMD <= 1'b1;
        tick(1);
        ENABLE_CMD <= 1'b0;
        read_chk(16'h0004);
        DISABLE_CMD <= 1'b1;
        tick(1);
        DISABLE_CMD <= 1'b0;
        read_chk(16'h0000);
        // Enable and disable together: enable wins
        ENABLE_CMD  <= 1'b1;
        DISABLE_CMD <= 1'b1;
        tick(1);
        ENABLE_CMD  <= 1'b0;
        DISABLE_CMD <= 1'b0;
        read_chk(16'h0004);
        DISABLE_CMD <= 1'b1;
        tick(1);
        DISABLE_CMD <= 1'b0;
        read_chk(16'h0000);
        SELFTEST_DONE <= 1'b1;
        read_chk(16'h0000);
        SELFTEST_PASS <= 1'b0;
        tick(1);
        SELFTEST_DONE <= 1'b0;
        read_chk(16'h0040);
        WARN_ROUTE <= 9'h040;
        read_chk(16'h0041);
        CE         <= 1'b0;
        RAIL_FAULT <= 1'b1;
        read_chk(16'h0041);
        CE         <= 1'b1;
        RAIL_FAULT <= 1'b0;
        WARN_ROUTE <= 9'h000;
        rst();
        read_chk(16'h0000);
        CFG_A          <= 16'h0001;
        RESERVED_WRITE <= 1'b1;
        tick(1);
        RESERVED_WRITE <= 1'b0;
        read_chk(16'h0000);
        MODE <= pfs_pkg::PFS_ST_ACTIVE;
        tick(2);
        CFG_B <= 16'h8000;
        read_chk(16'h0010);
        ALARM_ROUTE <= 9'h010;
        read_chk(16'h0012);
        ALARM_ROUTE <= 9'h020;
        for (int i = 0; i < 2; i++) begin
            rst();
            MODE <= pfs_pkg::PFS_ST_CONFIG2;
            tick(2);
            TEST_REG_WRITE <= (i == 0);
            RESERVED_WRITE <= (i == 1);
            tick(1);
            TEST_REG_WRITE <= 1'b0;
            RESERVED_WRITE <= 1'b0;
            read_chk(16'h0010);
        end
        rst();
        MODE <= pfs_pkg::PFS_ST_OTHER;
        tick(2);
        TRIM_DATA <= 64'h1;
        read_chk(16'h0000);
        MODE <= pfs_pkg::PFS_ST_CONFIG2;
        tick(2);
        TRIM_DATA <= 64'h3;
        read_chk(16'h0008);
        print_verdict();
    end
endmodule : test_primary_side_fault_status
